// File: iskip_defines.svh
`ifndef ISKIP_DEFINES_SVH
`define ISKIP_DEFINES_SVH
`define ISKIP_OPC_HI      15
`define ISKIP_OPC_LO      10
`define ISKIP_OPC_ZERO    6'h0f
`define ISKIP_OPC_NZERO   6'h12
`define ISKIP_DEST_BIT    9
`define ISKIP_ACC_BIT     8
`define ISKIP_DEST_WORKING_REGISTER   1'h0
`define ISKIP_ACC_ACCESS  1'h0
`define ISKIP_ACC_SPLIT   8'h80
`define ISKIP_ACC_HIBANK  4'hf
`endif

// File: iskip_pkg.sv
package iskip_pkg;
  typedef enum logic [3:0] {
    ISKIP_Q1 = 4'h1,
    ISKIP_Q2 = 4'h2,
    ISKIP_Q3 = 4'h4,
    ISKIP_Q4 = 4'h8
  } iskip_phase_t;
endpackage

// File: iskip_decode.sv
`timescale 1ns/1ps
`include "iskip_defines.svh"
module iskip_decode
  import iskip_pkg::*;
(
  input  wire logic [15:0] instr,
  input  wire logic [3:0]  bankSel,
  output logic             isZeroSkip,
  output logic             isNzeroSkip,
  output logic             destFile,
  output logic [11:0]      fileAddr
);
  wire logic [5:0] opc = instr[`ISKIP_OPC_HI:`ISKIP_OPC_LO];
  wire logic [7:0] f8  = instr[7:0];
  wire logic       acc = instr[`ISKIP_ACC_BIT];
  wire logic       lowHalf = (f8 < `ISKIP_ACC_SPLIT);
  wire logic [3:0] accBank = lowHalf ? 4'h0 : `ISKIP_ACC_HIBANK;
  assign isZeroSkip  = (opc == `ISKIP_OPC_ZERO);
  assign isNzeroSkip = (opc == `ISKIP_OPC_NZERO);
  assign destFile    = (instr[`ISKIP_DEST_BIT] != `ISKIP_DEST_WORKING_REGISTER);
  assign fileAddr = {(acc == `ISKIP_ACC_ACCESS) ? accBank : bankSel, f8};
endmodule // iskip_decode

// File: iskip_exec.sv
`timescale 1ns/1ps
`include "iskip_defines.svh"
module iskip_exec
  import iskip_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        ce,
  input  wire logic        instrValid,
  input  wire logic [15:0] instr,
  input  wire logic        nextTwoWord,
  input  wire logic [3:0]  bankSel,
  input  wire logic [7:0]  fileRdData,
  output logic [11:0]      fileAddr,
  output logic             fileRdEn,
  output logic             fileWrEn,
  output logic [7:0]       fileWrData,
  output logic             wregWrEn,
  output logic [7:0]       wregWrData,
  output logic             flushFetch,
  output logic             noOpCycle,
  output logic             busy,
  output logic [3:0]       phase
);
  //--------------------------------------------------------------
  // Decode
  //--------------------------------------------------------------
  logic        isZ;
  logic        isNZ;
  logic        dFile;
  logic [11:0] addrDec;
  iskip_decode u_dec (
    .instr       (instr),
    .bankSel     (bankSel),
    .isZeroSkip  (isZ),
    .isNzeroSkip (isNZ),
    .destFile    (dFile),
    .fileAddr    (addrDec)
  );

  iskip_phase_t phase_reg;
  logic         active_reg;
  logic         zeroMode_reg;
  logic         destFile_reg;
  logic         twoWord_reg;
  logic [11:0]  addr_reg;
  logic [7:0]   data_reg;
  logic [1:0]   nops_reg;
  logic         fileRdEn_reg;
  logic         fileWrEn_reg;
  logic         wregWrEn_reg;
  logic         flush_reg;
  logic [7:0]   wrData_reg;
  logic         noOp_reg;

  wire logic       startNew = instrValid && (isZ || isNZ) && !active_reg
                              && (nops_reg == 2'h0);
  wire logic [7:0] incVal   = data_reg + 8'h01;
  wire logic       incZero  = (incVal == 8'h00);
  wire logic       takeSkip = zeroMode_reg ? incZero : !incZero;
  wire logic [1:0] nopCount = twoWord_reg ? 2'h2 : 2'h1;

  //--------------------------------------------------------------
  // Quarter-cycle sequencer
  //--------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      phase_reg    <= ISKIP_Q1;
      active_reg   <= 1'b0;
      zeroMode_reg <= 1'b0;
      destFile_reg <= 1'b1;
      twoWord_reg  <= 1'b0;
      addr_reg     <= 12'h000;
      data_reg     <= 8'h00;
      nops_reg     <= 2'h0;
      fileRdEn_reg <= 1'b0;
      fileWrEn_reg <= 1'b0;
      wregWrEn_reg <= 1'b0;
      flush_reg    <= 1'b0;
      wrData_reg   <= 8'h00;
      noOp_reg     <= 1'b0;
    end else if (ce) begin
      fileRdEn_reg <= 1'b0;
      fileWrEn_reg <= 1'b0;
      wregWrEn_reg <= 1'b0;
      flush_reg    <= 1'b0;
      case (phase_reg)
        ISKIP_Q1: begin
          if (startNew) begin
            active_reg   <= 1'b1;
            zeroMode_reg <= isZ;
            destFile_reg <= dFile;
            twoWord_reg  <= nextTwoWord;
            addr_reg     <= addrDec;
            fileRdEn_reg <= 1'b1;
          end
          if (active_reg || startNew || nops_reg != 2'h0) begin
            phase_reg <= ISKIP_Q2;
          end
        end
        ISKIP_Q2: begin
          if (active_reg) begin
            data_reg <= fileRdData;
          end
          phase_reg <= ISKIP_Q3;
        end
        ISKIP_Q3: begin
          if (active_reg) begin
            wrData_reg <= incVal;
          end
          phase_reg <= ISKIP_Q4;
        end
        ISKIP_Q4: begin
          if (active_reg) begin
            fileWrEn_reg <= destFile_reg;
            wregWrEn_reg <= !destFile_reg;
            active_reg   <= 1'b0;
            if (takeSkip) begin
              nops_reg  <= nopCount;
              noOp_reg  <= 1'b1;
              flush_reg <= 1'b1;
            end
          end else if (nops_reg != 2'h0) begin
            nops_reg <= nops_reg - 2'h1;
            // Output stays a flop: drops with the last no-op cycle
            noOp_reg <= (nops_reg != 2'h1);
          end
          phase_reg <= ISKIP_Q1;
        end
        default: begin
          phase_reg <= ISKIP_Q1;
        end
      endcase
    end
  end

  assign fileAddr   = addr_reg;
  assign fileRdEn   = fileRdEn_reg;
  assign fileWrEn   = fileWrEn_reg;
  assign fileWrData = wrData_reg;
  assign wregWrEn   = wregWrEn_reg;
  assign wregWrData = wrData_reg;
  assign flushFetch = flush_reg;
  assign noOpCycle  = noOp_reg;
  assign busy       = active_reg;
  assign phase      = phase_reg;

  //--------------------------------------------------------------
  // Checks
  //--------------------------------------------------------------
  property p_skip_nop;
    @(posedge clk) disable iff (!resetn)
    $rose(flush_reg) |-> noOpCycle;
  endproperty
  a_skip_nop: assert property (p_skip_nop) else $error("no no-op after skip");

  property p_two_nop;
    @(posedge clk) disable iff (!resetn)
    (ce && phase_reg == ISKIP_Q4 && active_reg && takeSkip && twoWord_reg)
      |=> (nops_reg == 2'h2);
  endproperty
  a_two_nop: assert property (p_two_nop) else $error("two-word skip count");

  property p_dest;
    @(posedge clk) disable iff (!resetn)
    fileWrEn_reg |-> !wregWrEn_reg && destFile_reg;
  endproperty
  a_dest: assert property (p_dest) else $error("wrong destination");

  property p_wrap;
    @(posedge clk) disable iff (!resetn)
    (ce && phase_reg == ISKIP_Q3 && active_reg) |=>
      (wrData_reg == 8'($past(data_reg) + 8'h01));
  endproperty
  a_wrap: assert property (p_wrap) else $error("bad increment");

  property p_zero_skip;
    @(posedge clk) disable iff (!resetn)
    (ce && phase_reg == ISKIP_Q4 && active_reg && zeroMode_reg && incZero)
      |=> flush_reg;
  endproperty
  a_zero_skip: assert property (p_zero_skip) else $error("zero skip miss");

  property p_nz_skip;
    @(posedge clk) disable iff (!resetn)
    (ce && phase_reg == ISKIP_Q4 && active_reg && !zeroMode_reg && !incZero)
      |=> flush_reg;
  endproperty
  a_nz_skip: assert property (p_nz_skip) else $error("nonzero skip miss");

  property p_phase;
    @(posedge clk) disable iff (!resetn)
    (ce && phase_reg == ISKIP_Q2) |=> (phase_reg == ISKIP_Q3);
  endproperty
  a_phase: assert property (p_phase) else $error("phase order");

  property p_freeze;
    @(posedge clk) disable iff (!resetn)
    !ce |=> $stable(phase_reg) && $stable(nops_reg) && $stable(active_reg);
  endproperty
  a_freeze: assert property (p_freeze) else $error("state moved");

  property p_opc;
    @(posedge clk) disable iff (!resetn)
    (instr[`ISKIP_OPC_HI:`ISKIP_OPC_LO] == `ISKIP_OPC_ZERO) |-> isZ && !isNZ;
  endproperty
  a_opc: assert property (p_opc) else $error("zero opcode");

  property p_opc2;
    @(posedge clk) disable iff (!resetn)
    (instr[`ISKIP_OPC_HI:`ISKIP_OPC_LO] == `ISKIP_OPC_NZERO) |-> isNZ && !isZ;
  endproperty
  a_opc2: assert property (p_opc2) else $error("nonzero opcode");

  property p_bank;
    @(posedge clk) disable iff (!resetn)
    instr[`ISKIP_ACC_BIT] |-> (addrDec[11:8] == bankSel);
  endproperty
  a_bank: assert property (p_bank) else $error("bank select");
endmodule // iskip_exec

// File: iskip_exec_tb.sv
`timescale 1ns/1ps
`include "iskip_defines.svh"
module iskip_exec_tb;
  import iskip_pkg::*;
  logic clk = 1'b0;
  logic resetn, ce, instrValid, nextTwoWord;
  logic [15:0] instr;
  logic [3:0] bankSel, phase;
  logic [7:0] fileRdData, fileWrData, wregWrData;
  logic [11:0] fileAddr;
  logic fileRdEn, fileWrEn, wregWrEn, flushFetch, noOpCycle, busy;
  int n_fail = 0;
  int num_checks = 0;

  always #2.5 clk = ~clk;

  iskip_exec i_dut (.clk(clk), .resetn(resetn), .ce(ce),
    .instrValid(instrValid), .instr(instr), .nextTwoWord(nextTwoWord),
    .bankSel(bankSel), .fileRdData(fileRdData), .fileAddr(fileAddr),
    .fileRdEn(fileRdEn), .fileWrEn(fileWrEn), .fileWrData(fileWrData),
    .wregWrEn(wregWrEn), .wregWrData(wregWrData),
    .flushFetch(flushFetch), .noOpCycle(noOpCycle), .busy(busy),
    .phase(phase));

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [15:0] e,
                       input logic [15:0] g);
    num_checks++;
    if (g !== e) begin
      n_fail++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic print_verdict();
    if (n_fail == 0 && num_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask

  // One instruction: drive at Q1, check read, write-back and no-op run
  task automatic run(input logic [5:0] op, input logic d, a,
                     input logic [7:0] f, rd, input logic two, skip);
    logic [7:0] res;
    logic [11:0] adr;
    int cnt;
    res = rd + 8'h01;
    adr = a ? {bankSel, f} : {(f < `ISKIP_ACC_SPLIT) ? 4'h0 : 4'hf, f};
    cnt = 0;
    while (phase !== ISKIP_Q1) @(negedge clk);
    instr = {op, d, a, f};
    instrValid = 1'b1;
    nextTwoWord = two;
    fileRdData = rd;
    @(negedge clk);
    instrValid = 1'b0;
    check("fileRdEn", 16'h1, {15'h0, fileRdEn});
    check("fileAddr", {4'h0, adr}, {4'h0, fileAddr});
    check("phaseRead", 16'h2, {12'h0, phase});
    repeat (3) @(negedge clk);
    check("phaseWrite", 16'h1, {12'h0, phase});
    check("fileWrEn", {15'h0, d}, {15'h0, fileWrEn});
    check("wregWrEn", {15'h0, !d}, {15'h0, wregWrEn});
    check("wrData", {8'h0, res}, {8'h0, d ? fileWrData : wregWrData});
    check("flushFetch", {15'h0, skip}, {15'h0, flushFetch});
    while (noOpCycle === 1'b1 && cnt < 20) begin
      cnt++;
      @(negedge clk);
    end
    check("noOpCycles", skip ? (two ? 16'h8 : 16'h4) : 16'h0, cnt[15:0]);
    cnt = 0;
    while (busy !== 1'b0 && cnt < 20) begin
      cnt++;
      @(negedge clk);
    end
    check("busyIdle", 16'h0, {15'h0, busy});
  endtask

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic zero_wrap_skip();
    bankSel = 4'h5;
    run(`ISKIP_OPC_ZERO, 1'b1, 1'b1, 8'h34, 8'hff, 1'b0, 1'b1);
  endtask

  task automatic zero_no_skip();
    run(`ISKIP_OPC_ZERO, 1'b0, 1'b0, 8'h20, 8'h10, 1'b0, 1'b0);
  endtask

  task automatic nzero_two_word();
    run(`ISKIP_OPC_NZERO, 1'b0, 1'b0, 8'h90, 8'h10, 1'b1, 1'b1);
  endtask

  task automatic nzero_wrap_no_skip();
    bankSel = 4'ha;
    run(`ISKIP_OPC_NZERO, 1'b1, 1'b1, 8'h7f, 8'hff, 1'b1, 1'b0);
  endtask

  // Other opcodes, 0x0a and the neighbours 0x0e and 0x13, must not start a read
  task automatic other_ops_ignored();
    logic [5:0] ops [3] = '{6'h0a, 6'h0e, 6'h13};
    foreach (ops[i]) begin
      while (phase !== ISKIP_Q1) @(negedge clk);
      instr = {ops[i], 10'h155};
      instrValid = 1'b1;
      @(negedge clk);
      instrValid = 1'b0;
      check("refusedRd", 16'h0, {15'h0, fileRdEn});
      check("refusedBusy", 16'h0, {15'h0, busy});
      @(negedge clk);
    end
  endtask

  // Clock enable low holds the sequence mid-instruction
  task automatic ce_freeze();
    while (phase !== ISKIP_Q1) @(negedge clk);
    instr = {`ISKIP_OPC_ZERO, 2'h3, 8'h41};
    instrValid = 1'b1;
    fileRdData = 8'h05;
    @(negedge clk);
    instrValid = 1'b0;
    ce = 1'b0;
    repeat (3) @(negedge clk);
    check("frozenPhase", 16'h2, {12'h0, phase});
    check("frozenRdEn", 16'h1, {15'h0, fileRdEn});
    ce = 1'b1;
    repeat (3) @(negedge clk);
    check("thawWrEn", 16'h1, {15'h0, fileWrEn});
    check("thawData", 16'h6, {8'h0, fileWrData});
    check("thawFlush", 16'h0, {15'h0, flushFetch});
  endtask

  // Reset in mid-instruction abandons it
  task automatic reset_mid();
    while (phase !== ISKIP_Q1) @(negedge clk);
    instr = {`ISKIP_OPC_NZERO, 2'h3, 8'h22};
    instrValid = 1'b1;
    @(negedge clk);
    instrValid = 1'b0;
    resetn = 1'b0;
    repeat (2) @(negedge clk);
    check("rstBusy", 16'h0, {15'h0, busy});
    check("rstRdEn", 16'h0, {15'h0, fileRdEn});
    check("rstNoOp", 16'h0, {15'h0, noOpCycle});
    check("rstPhase", 16'h1, {12'h0, phase});
    resetn = 1'b1;
  endtask

  initial begin
    resetn = 1'b0;
    ce = 1'b1;
    instrValid = 1'b0;
    instr = 16'h0000;
    nextTwoWord = 1'b0;
    bankSel = 4'h0;
    fileRdData = 8'h00;
    repeat (2) @(negedge clk);
    check("phaseReset", 16'h1, {12'h0, phase});
    resetn = 1'b1;
    zero_wrap_skip();
    zero_no_skip();
    nzero_two_word();
    nzero_wrap_no_skip();
    ce_freeze();
    reset_mid();
    other_ops_ignored();
    print_verdict();
  end

  initial begin
    #10000;
    n_fail++;
    print_verdict();
  end
endmodule // iskip_exec_tb
